// ### common/gbcs_pkg.sv
// Package: types and constants for the bus command and status block
package gbcs_pkg;

	// Status byte bit positions
	localparam int STB_ERR_BIT  = 0;
	localparam int STB_OVR_BIT  = 1;
	localparam int STB_UND_BIT  = 2;
	localparam int STB_MC_BIT   = 3;
	localparam int STB_RQS_BIT  = 6;
	localparam logic [7:0] STB_RESET = 8'h00;

	// Service request mask bits (mask command value)
	localparam logic [3:0] MASK_ERR = 4'h1;
	localparam logic [3:0] MASK_OVR = 4'h2;
	localparam logic [3:0] MASK_UND = 4'h4;
	localparam logic [3:0] MASK_OPC = 4'h8;
	localparam logic [3:0] MASK_RESET = 4'h0;

	// Measurement modes
	typedef enum logic [2:0] {
		GBCS_MEAS_FWD_CW  = 3'b000,
		GBCS_MEAS_FWD_DBM = 3'b001,
		GBCS_MEAS_REF_CW  = 3'b010,
		GBCS_MEAS_REF_DBM = 3'b011,
		GBCS_MEAS_SWR     = 3'b100,
		GBCS_MEAS_RLOSS   = 3'b101,
		GBCS_MEAS_MIN     = 3'b110,
		GBCS_MEAS_MAX     = 3'b111
	} gbcs_meas_t;

	// Trigger modes
	typedef enum logic [2:0] {
		GBCS_TRG_CONT_TALK  = 3'b000,
		GBCS_TRG_ONE_TALK   = 3'b001,
		GBCS_TRG_CONT_GET   = 3'b010,
		GBCS_TRG_ONE_GET    = 3'b011,
		GBCS_TRG_CONT_MEAS  = 3'b100,
		GBCS_TRG_ONE_MEAS   = 3'b101
	} gbcs_trig_t;

	// Terminator modes
	typedef enum logic [1:0] {
		GBCS_TERM_CRLF = 2'b00,
		GBCS_TERM_CR   = 2'b01,
		GBCS_TERM_NONE = 2'b10
	} gbcs_term_t;

	// Decoded interface messages, one pulse each
	typedef struct packed {
		logic go_to_local;
		logic local_lockout;
		logic device_clear;
		logic sel_device_clear;
		logic group_trigger;
		logic poll_enable;
		logic poll_disable;
		logic my_listen;
		logic my_talk;
		logic unlisten;
		logic untalk;
	} gbcs_msg_t;

	// Device settings restored by a clear
	typedef struct packed {
		gbcs_meas_t meas_mode;
		logic       auto_range_on;
		gbcs_term_t terminators;
		logic       prefixes_on;
		gbcs_trig_t trig_mode;
		logic [3:0] srq_mask;
		logic       eoi_on_final_byte;
	} gbcs_cfg_t;

	localparam gbcs_cfg_t CFG_DEFAULT = '{
		meas_mode:         GBCS_MEAS_FWD_CW,
		auto_range_on:     1'b1,
		terminators:       GBCS_TERM_CRLF,
		prefixes_on:       1'b1,
		trig_mode:         GBCS_TRG_ONE_TALK,
		srq_mask:          MASK_RESET,
		eoi_on_final_byte: 1'b1
	};

	// Interface state indications
	typedef struct packed {
		logic remote;
		logic lockout;
		logic listen;
		logic talk;
	} gbcs_ind_t;

endpackage : gbcs_pkg

// ### verilog/gbcs_msg_sync.sv
// Two-stage synchroniser for the bus management lines
`timescale 1ns/100ps
module gbcs_msg_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Lines
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	initial begin
		if (WIDTH < 1) $error("gbcs_msg_sync: WIDTH must be positive");
	end

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : gbcs_msg_sync

// ### verilog/gbcs_bus_cmd.sv
// Device-side general bus command handling and serial poll status byte
// Operation
// - Remote entered only when addressed to listen with remote enable true.
// - Entering remote turns on the remote indication.
// - Go-to-local returns to local but keeps lockout in force.
// - Go-to-local clears remote indication; listen indication stays unchanged.
// - Lockout takes effect only while remote enable is asserted.
// - Lockout disables the front-panel push buttons.
// - Lockout clears whenever remote enable is deasserted.
// - Interface clear idles talker and listener and aborts activity.
// - Interface clear drops remote, talk, listen, lockout and their indications.
// - Device clear restores defaults without touching interface mode.
// - Defaults: forward carrier, autorange, CR LF, prefixes, one-shot talk, no SRQ, EOI.
// - Selective clear restores defaults only when addressed.
// - Group trigger starts a measurement only in the two trigger-on-GET modes.
// - In serial poll and addressed to talk, status byte goes on bus.
// - Poll disable clears service-request bit and leaves poll mode.
// - Status bits read one when condition true, zero otherwise.
// - Bit 6 set on service request, cleared when serially polled.
// - Bit 3 set on reading complete, cleared when a reading is requested.
// - Bit 2 set on underrange reading, cleared when a reading is requested.
// - Bit 1 set on overrange reading, cleared when a reading is requested.
// - Bit 0 cleared only by reading the error detail word.
// - Illegal command records an error and is not executed.
// - Service request raised only for mask-enabled conditions.
`timescale 1ns/100ps
module gbcs_bus_cmd
	import gbcs_pkg::*;
(
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               reset,
	// Bus management pins (asynchronous)
	input  wire logic               ren_pin,
	input  wire logic               ifc_pin,
	// Decoded interface messages from the acceptor
	input  wire gbcs_pkg::gbcs_msg_t msg,
	// Device-dependent command results from the parser
	input  wire logic               cfg_wr,
	input  wire gbcs_pkg::gbcs_cfg_t cfg_wdata,
	input  wire logic               cmd_illegal,
	input  wire logic               opt_illegal,
	input  wire logic               selftest_fail,
	input  wire logic               reading_request,
	input  wire logic               error_word_read,
	// Measurement engine
	input  wire logic               reading_done,
	input  wire logic               reading_under,
	input  wire logic               reading_over,
	output logic                    meas_start,
	// Serial poll byte to the talker
	output logic                    poll_byte_valid,
	output logic [7:0]              poll_byte,
	// Service request pin, open collector
	output logic                    srq_out,
	output logic                    srq_oe_n,
	// Front panel and configuration
	output logic                    panel_enable,
	output gbcs_pkg::gbcs_cfg_t     cfg,
	output gbcs_pkg::gbcs_ind_t     ind,
	output logic                    bus_abort
);

	// Whole state of the block
	typedef struct packed {
		gbcs_ind_t  ind;
		logic       spoll;
		gbcs_cfg_t  cfg;
		logic [7:0] stb;
		logic       start;
		logic       abort;
	} gbcs_state_t;

	gbcs_state_t state_r;
	gbcs_state_t state_nxt;
	logic        ren_s;
	logic        ifc_s;

	// Pins pass two flops before use
	gbcs_msg_sync #(
		.WIDTH (2)
	) u_gbcs_msg_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({ren_pin, ifc_pin}),
		.sync_out ({ren_s, ifc_s})
	);

	// Trigger modes that respond to group trigger
	function automatic logic on_get(input gbcs_trig_t m);
		return (m == GBCS_TRG_CONT_GET) || (m == GBCS_TRG_ONE_GET);
	endfunction : on_get

	logic addressed;
	logic err_ev;
	logic srq_cause;
	assign addressed = state_r.ind.listen | state_r.ind.talk;
	assign err_ev    = cmd_illegal | opt_illegal | selftest_fail;

	// Next-state logic
	always_comb begin
		state_nxt       = state_r;
		state_nxt.start = 1'b0;
		state_nxt.abort = 1'b0;
		srq_cause       = 1'b0;

		// Addressing
		if (msg.my_listen) begin
			state_nxt.ind.listen = 1'b1;
		end
		if (msg.unlisten) begin
			state_nxt.ind.listen = 1'b0;
		end
		if (msg.my_talk) begin
			state_nxt.ind.talk = 1'b1;
			state_nxt.ind.listen = msg.my_listen ? 1'b1 : state_nxt.ind.listen;
		end
		if (msg.untalk) begin
			state_nxt.ind.talk = 1'b0;
		end

		// Remote entry when addressed to listen under remote enable
		if (ren_s && msg.my_listen) begin
			state_nxt.ind.remote = 1'b1;
		end
		// Go-to-local keeps lockout and listen
		if (msg.go_to_local) begin
			state_nxt.ind.remote = 1'b0;
		end
		// Lockout only under remote enable
		if (msg.local_lockout && ren_s) begin
			state_nxt.ind.lockout = 1'b1;
		end
		// Remote enable dropped clears remote and lockout
		if (!ren_s) begin
			state_nxt.ind.remote  = 1'b0;
			state_nxt.ind.lockout = 1'b0;
		end

		// Serial poll mode
		if (msg.poll_enable) begin
			state_nxt.spoll = 1'b1;
		end
		if (msg.poll_disable) begin
			state_nxt.spoll = 1'b0;
		end

		// Configuration from parser; writes flagged cmd_illegal or opt_illegal are dropped here
		if (cfg_wr && !cmd_illegal && !opt_illegal) begin
			state_nxt.cfg = cfg_wdata;
		end
		// Device clear, selective only when addressed; interface mode kept
		if (msg.device_clear || (msg.sel_device_clear && addressed)) begin
			state_nxt.cfg = CFG_DEFAULT;
		end

		// Group trigger only in the trigger-on-GET modes
		if (msg.group_trigger && on_get(state_r.cfg.trig_mode)) begin
			state_nxt.start = 1'b1;
		end

		// Status clears first, so a same-cycle event wins
		if (reading_request) begin
			state_nxt.stb[STB_MC_BIT]  = 1'b0;
			state_nxt.stb[STB_UND_BIT] = 1'b0;
			state_nxt.stb[STB_OVR_BIT] = 1'b0;
		end
		if (error_word_read) begin
			state_nxt.stb[STB_ERR_BIT] = 1'b0;
		end
		if (msg.poll_disable || (state_r.spoll && state_r.ind.talk && poll_byte_valid)) begin
			state_nxt.stb[STB_RQS_BIT] = 1'b0;
		end
		if (reading_done) begin
			state_nxt.stb[STB_MC_BIT] = 1'b1;
			if (reading_under) begin
				state_nxt.stb[STB_UND_BIT] = 1'b1;
			end
			if (reading_over) begin
				state_nxt.stb[STB_OVR_BIT] = 1'b1;
			end
		end
		if (err_ev) begin
			state_nxt.stb[STB_ERR_BIT] = 1'b1;
		end

		// Service request only from enabled sources
		srq_cause = (err_ev && |(state_r.cfg.srq_mask & MASK_ERR))
			|| (reading_done && reading_over && |(state_r.cfg.srq_mask & MASK_OVR))
			|| (reading_done && reading_under && |(state_r.cfg.srq_mask & MASK_UND))
			|| (reading_done && |(state_r.cfg.srq_mask & MASK_OPC));
		if (srq_cause) begin
			state_nxt.stb[STB_RQS_BIT] = 1'b1;
		end
		state_nxt.stb[7] = 1'b0;
		state_nxt.stb[5] = 1'b0;
		state_nxt.stb[4] = 1'b0;

		// Interface clear overrides everything on the interface side
		if (ifc_s) begin
			state_nxt.ind   = '0;
			state_nxt.spoll = 1'b0;
			state_nxt.abort = 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r       <= '0;
			state_r.cfg   <= CFG_DEFAULT;
			state_r.stb   <= STB_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs; byte offered while polled and talking
	assign poll_byte_valid = state_r.spoll & state_r.ind.talk;
	assign poll_byte       = state_r.stb;
	assign srq_out         = 1'b0;
	assign srq_oe_n        = ~state_r.stb[STB_RQS_BIT];
	assign panel_enable    = ~state_r.ind.lockout;
	assign cfg             = state_r.cfg;
	assign ind             = state_r.ind;
	assign meas_start      = state_r.start;
	assign bus_abort       = state_r.abort;

	// Assertions
	a_llo_needs_ren: assert property (@(posedge sys_clk) disable iff (reset)
		!ren_s |=> !state_r.ind.lockout)
		else $error("lockout held without remote enable");
	a_remote_needs_ren: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(state_r.ind.remote) |-> $past(ren_s) && $past(msg.my_listen))
		else $error("remote entered without addressing");
	a_gtl_keeps_llo: assert property (@(posedge sys_clk) disable iff (reset)
		msg.go_to_local && state_r.ind.lockout && ren_s && !ifc_s
		|=> !state_r.ind.remote && state_r.ind.lockout)
		else $error("go to local mishandled lockout");
	a_gtl_keeps_listen: assert property (@(posedge sys_clk) disable iff (reset)
		msg.go_to_local && state_r.ind.listen && !msg.unlisten && !ifc_s
		|=> state_r.ind.listen)
		else $error("go to local dropped listen");
	a_ifc_idles_all: assert property (@(posedge sys_clk) disable iff (reset)
		ifc_s |=> state_r.ind == '0 && bus_abort)
		else $error("interface clear left state");
	a_sdc_unaddr: assert property (@(posedge sys_clk) disable iff (reset)
		msg.sel_device_clear && !addressed && !msg.device_clear && !cfg_wr
		|=> $stable(cfg))
		else $error("unaddressed selective clear acted");
	a_dcl_default: assert property (@(posedge sys_clk) disable iff (reset)
		msg.device_clear |=> cfg == CFG_DEFAULT)
		else $error("device clear did not restore defaults");
	a_get_mode: assert property (@(posedge sys_clk) disable iff (reset)
		meas_start |-> $past(msg.group_trigger) && on_get($past(state_r.cfg.trig_mode)))
		else $error("trigger outside group trigger mode");
	a_unused_zero: assert property (@(posedge sys_clk) disable iff (reset)
		poll_byte[7] == 1'b0 && poll_byte[5:4] == 2'b00)
		else $error("unused status bits set");
	a_err_sticky: assert property (@(posedge sys_clk) disable iff (reset)
		poll_byte[STB_ERR_BIT] && !error_word_read |=> poll_byte[STB_ERR_BIT])
		else $error("error bit cleared without detail read");
	a_srq_pin: assert property (@(posedge sys_clk) disable iff (reset)
		srq_oe_n == !poll_byte[STB_RQS_BIT] && panel_enable == !ind.lockout)
		else $error("service request pin mismatch");
	a_spd_clears: assert property (@(posedge sys_clk) disable iff (reset)
		msg.poll_disable && !srq_cause |=> !poll_byte[STB_RQS_BIT] && !state_r.spoll)
		else $error("poll disable did not clear");

	// Interface mode: remote, lockout, abort and clears; group trigger and illegal writes
	a_remote_ind: assert property (@(posedge sys_clk) disable iff (reset)
		ren_s && msg.my_listen && !msg.go_to_local && !ifc_s |=> state_r.ind.remote)
		else $error("remote indication not turned on");
	a_llo_refused: assert property (@(posedge sys_clk) disable iff (reset)
		msg.local_lockout && !ren_s |=> !state_r.ind.lockout)
		else $error("lockout taken without remote enable");
	a_panel_lock: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(state_r.ind.lockout) |-> !panel_enable && $past(ren_s) && $past(msg.local_lockout))
		else $error("panel left enabled under lockout");
	a_abort_cause: assert property (@(posedge sys_clk) disable iff (reset)
		bus_abort |-> $past(ifc_s))
		else $error("abort without interface clear");
	a_dcl_keeps_mode: assert property (@(posedge sys_clk) disable iff (reset)
		msg.device_clear && $onehot(msg) && ren_s && !ifc_s |=> $stable(ind))
		else $error("device clear changed interface mode");
	a_default_values: assert property (@(posedge sys_clk) disable iff (reset)
		msg.device_clear |=> cfg.meas_mode == GBCS_MEAS_FWD_CW && cfg.auto_range_on
		&& cfg.terminators == GBCS_TERM_CRLF && cfg.prefixes_on
		&& cfg.trig_mode == GBCS_TRG_ONE_TALK && cfg.srq_mask == 4'h0 && cfg.eoi_on_final_byte)
		else $error("default settings wrong");
	a_sdc_addr: assert property (@(posedge sys_clk) disable iff (reset)
		msg.sel_device_clear && addressed |=> cfg == CFG_DEFAULT)
		else $error("addressed selective clear ignored");
	a_get_ignored: assert property (@(posedge sys_clk) disable iff (reset)
		msg.group_trigger && !on_get(state_r.cfg.trig_mode) |=> !meas_start)
		else $error("group trigger acted in wrong mode");
	a_illegal_nowrite: assert property (@(posedge sys_clk) disable iff (reset)
		cfg_wr && (cmd_illegal || opt_illegal) && !msg.device_clear && !msg.sel_device_clear
		|=> $stable(cfg))
		else $error("illegal command was executed");

	// Poll byte offered to the talker
	a_poll_valid: assert property (@(posedge sys_clk) disable iff (reset)
		msg.poll_enable && msg.my_talk && !msg.poll_disable && !msg.untalk && !ifc_s
		|=> poll_byte_valid)
		else $error("status byte not offered");

	// Status bits; set wins, so clears are checked only without a same-cycle event
	a_mc_set: assert property (@(posedge sys_clk) disable iff (reset)
		reading_done |=> poll_byte[STB_MC_BIT])
		else $error("complete bit not set");
	a_mc_clear: assert property (@(posedge sys_clk) disable iff (reset)
		reading_request && !reading_done
		|=> !poll_byte[STB_MC_BIT] && !poll_byte[STB_UND_BIT] && !poll_byte[STB_OVR_BIT])
		else $error("reading request did not clear");
	a_under_set: assert property (@(posedge sys_clk) disable iff (reset)
		reading_done && reading_under |=> poll_byte[STB_UND_BIT])
		else $error("underrange bit not set");
	a_over_set: assert property (@(posedge sys_clk) disable iff (reset)
		reading_done && reading_over |=> poll_byte[STB_OVR_BIT])
		else $error("overrange bit not set");
	a_over_cause: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(poll_byte[STB_OVR_BIT]) |-> $past(reading_done) && $past(reading_over))
		else $error("overrange bit set without cause");
	a_err_set: assert property (@(posedge sys_clk) disable iff (reset)
		err_ev |=> poll_byte[STB_ERR_BIT])
		else $error("error bit not set");
	a_srq_set: assert property (@(posedge sys_clk) disable iff (reset)
		srq_cause |=> poll_byte[STB_RQS_BIT])
		else $error("request bit not set");
	a_srq_masked: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(poll_byte[STB_RQS_BIT]) |-> $past(srq_cause))
		else $error("request from a masked source");
	a_rqs_polled: assert property (@(posedge sys_clk) disable iff (reset)
		poll_byte_valid && !srq_cause |=> !poll_byte[STB_RQS_BIT])
		else $error("request bit survived the poll");

	// Coverage of main scenarios
	c_remote_lockout: cover property (@(posedge sys_clk) disable iff (reset)
		state_r.ind.remote && state_r.ind.lockout);
	c_poll_served: cover property (@(posedge sys_clk) disable iff (reset)
		poll_byte_valid && poll_byte[STB_RQS_BIT]);
	c_get_trigger: cover property (@(posedge sys_clk) disable iff (reset) meas_start);
	c_ifc_abort: cover property (@(posedge sys_clk) disable iff (reset) bus_abort);
	c_sel_clear: cover property (@(posedge sys_clk) disable iff (reset)
		msg.sel_device_clear && addressed);

endmodule : gbcs_bus_cmd

// ### dv/gbcs_ctrl_model.sv
// Behavioural system controller: management lines and decoded messages
`timescale 1ns/100ps
module gbcs_ctrl_model
	import gbcs_pkg::*;
(
	// Clock
	input  wire logic           sys_clk,
	// Management lines and messages
	output logic                ren_pin,
	output logic                ifc_pin,
	output gbcs_pkg::gbcs_msg_t msg,
	// Service request, open collector
	input  wire logic           srq_out,
	input  wire logic           srq_oe_n,
	output logic                srq_seen
);
	// Line is pulled up, so released means high and no request
	assign srq_seen = !(srq_oe_n ? 1'b1 : srq_out);
	initial begin
		ren_pin = 1'b0;
		ifc_pin = 1'b0;
		msg = '0;
	end
	// Lines change at falling edges only
	task automatic set_ren(input logic v);
		@(negedge sys_clk);
		ren_pin = v;
	endtask : set_ren
	// One-cycle message; addressing after remote enable is up to the caller
	task automatic send(input int k);
		@(negedge sys_clk);
		msg = gbcs_msg_t'(11'h001 << k);
		@(negedge sys_clk);
		msg = '0;
	endtask : send
	// Clear held two cycles, longer than one sync delay step
	task automatic pulse_ifc();
		@(negedge sys_clk);
		ifc_pin = 1'b1;
		repeat (2) @(negedge sys_clk);
		ifc_pin = 1'b0;
	endtask : pulse_ifc
endmodule : gbcs_ctrl_model

// ### dv/gbcs_bus_cmd_tb_top.sv
// Self-checking bench for the bus command and status block
`timescale 1ns/100ps
module gbcs_bus_cmd_tb_top;
	import gbcs_pkg::*;
	// Message bit positions and parser strobe positions
	localparam int M_GTL = 10, M_LLO = 9, M_DCL = 8, M_SDC = 7, M_GET = 6, M_SPE = 5;
	localparam int M_SPD = 4, M_MLA = 3, M_MTA = 2, M_UNL = 1, M_UNT = 0;
	localparam int S_OPT = 3, S_ST = 2, S_REQ = 1, S_ERR = 0;
	// Factory settings written out independently of the package
	localparam gbcs_cfg_t DEF = '{GBCS_MEAS_FWD_CW, 1'b1, GBCS_TERM_CRLF, 1'b1,
		GBCS_TRG_ONE_TALK, 4'h0, 1'b1};
	logic       sys_clk = 1'b0;
	logic       reset = 1'b1;
	logic       ren_pin, ifc_pin, srq_seen, meas_start, poll_byte_valid;
	logic       srq_out, srq_oe_n, panel_enable, bus_abort;
	gbcs_msg_t  msg;
	logic       cfg_wr = 1'b0;
	gbcs_cfg_t  cfg_wdata = DEF;
	gbcs_cfg_t  cfg;
	gbcs_cfg_t  c;
	gbcs_ind_t  ind;
	logic [4:0] st = 5'h00;
	logic       cmd_ill, opt_ill, st_fail, rd_req, err_rd;
	logic       rd_done = 1'b0;
	logic       rd_under = 1'b0;
	logic       rd_over = 1'b0;
	logic [7:0] poll_byte;
	int         n_errors = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	// Parser strobes fanned out by name
	assign {cmd_ill, opt_ill, st_fail, rd_req, err_rd} = st;

	gbcs_bus_cmd u_gbcs_bus_cmd (.sys_clk(sys_clk), .reset(reset), .ren_pin(ren_pin),
		.ifc_pin(ifc_pin), .msg(msg), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
		.cmd_illegal(cmd_ill), .opt_illegal(opt_ill), .selftest_fail(st_fail),
		.reading_request(rd_req), .error_word_read(err_rd), .reading_done(rd_done),
		.reading_under(rd_under), .reading_over(rd_over), .meas_start(meas_start),
		.poll_byte_valid(poll_byte_valid), .poll_byte(poll_byte), .srq_out(srq_out),
		.srq_oe_n(srq_oe_n), .panel_enable(panel_enable), .cfg(cfg), .ind(ind),
		.bus_abort(bus_abort));
	gbcs_ctrl_model u_gbcs_ctrl_model (.sys_clk(sys_clk), .ren_pin(ren_pin),
		.ifc_pin(ifc_pin), .msg(msg), .srq_out(srq_out), .srq_oe_n(srq_oe_n),
		.srq_seen(srq_seen));

	// Clock and hang guard; the run needs well under a thousand cycles
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Checks: %0d, mismatches: %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	// Compare on four-state values so an unknown never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : idle

	task automatic pulse_st(input int k);
		@(negedge sys_clk);
		st[k] = 1'b1;
		@(negedge sys_clk);
		st = 5'h00;
	endtask : pulse_st

	task automatic wr_cfg(input gbcs_cfg_t v, input logic ill);
		@(negedge sys_clk);
		cfg_wr = 1'b1;
		cfg_wdata = v;
		st[4] = ill;
		@(negedge sys_clk);
		cfg_wr = 1'b0;
		st[4] = 1'b0;
	endtask : wr_cfg

	task automatic rd_finish(input logic u, input logic o);
		@(negedge sys_clk);
		rd_done = 1'b1;
		rd_under = u;
		rd_over = o;
		@(negedge sys_clk);
		rd_done = 1'b0;
	endtask : rd_finish

	task automatic t_remote();
		u_gbcs_ctrl_model.send(M_MLA);
		chk(ind, 4'h2);
		u_gbcs_ctrl_model.send(M_UNL);
		u_gbcs_ctrl_model.set_ren(1'b1);
		idle(4);
		u_gbcs_ctrl_model.send(M_MLA);
		chk(ind, 4'ha);
	endtask : t_remote

	// Lockout sent once without remote enable on purpose
	task automatic t_lockout();
		u_gbcs_ctrl_model.set_ren(1'b0);
		idle(4);
		u_gbcs_ctrl_model.send(M_LLO);
		chk(ind, 4'h2);
		chk(panel_enable, 1'b1);
		u_gbcs_ctrl_model.set_ren(1'b1);
		idle(4);
		u_gbcs_ctrl_model.send(M_LLO);
		chk(panel_enable, 1'b0);
		u_gbcs_ctrl_model.send(M_MLA);
		u_gbcs_ctrl_model.send(M_GTL);
		chk(ind, 4'h6);
		chk(panel_enable, 1'b0);
		u_gbcs_ctrl_model.set_ren(1'b0);
		idle(4);
		chk(ind, 4'h2);
		chk(panel_enable, 1'b1);
	endtask : t_lockout

	task automatic t_ifc();
		int k;
		u_gbcs_ctrl_model.set_ren(1'b1);
		idle(4);
		u_gbcs_ctrl_model.send(M_MTA);
		u_gbcs_ctrl_model.send(M_LLO);
		u_gbcs_ctrl_model.pulse_ifc();
		k = 0;
		while (bus_abort !== 1'b1 && k < 6) begin
			@(negedge sys_clk);
			k++;
		end
		chk(bus_abort, 1'b1);
		idle(3);
		chk(ind, 4'h0);
		chk(panel_enable, 1'b1);
		u_gbcs_ctrl_model.set_ren(1'b0);
	endtask : t_ifc

	task automatic t_clear();
		c = '{GBCS_MEAS_SWR, 1'b0, GBCS_TERM_NONE, 1'b0, GBCS_TRG_CONT_GET, 4'hf, 1'b0};
		wr_cfg(c, 1'b0);
		u_gbcs_ctrl_model.send(M_MLA);
		u_gbcs_ctrl_model.send(M_DCL);
		chk(cfg, DEF);
		chk(ind, 4'h2);
		wr_cfg(c, 1'b0);
		u_gbcs_ctrl_model.send(M_UNL);
		u_gbcs_ctrl_model.send(M_SDC);
		chk(cfg, c);
		u_gbcs_ctrl_model.send(M_MLA);
		u_gbcs_ctrl_model.send(M_SDC);
		chk(cfg, DEF);
		wr_cfg(c, 1'b1);
		chk(cfg, DEF);
		chk(poll_byte, 8'h01);
	endtask : t_clear

	task automatic t_trigger();
		for (int i = 0; i < 6; i++) begin
			c.trig_mode = gbcs_trig_t'(3'(i));
			wr_cfg(c, 1'b0);
			u_gbcs_ctrl_model.send(M_GET);
			chk(meas_start, i == 2 || i == 3);
		end
	endtask : t_trigger

	// Error bit survives a reading request; only the detail word clears it
	task automatic t_status();
		// Mask left fully open by the trigger scenario would raise requests here
		c.srq_mask = MASK_RESET;
		wr_cfg(c, 1'b0);
		pulse_st(S_REQ);
		chk(poll_byte, 8'h01);
		pulse_st(S_ERR);
		chk(poll_byte, 8'h00);
		pulse_st(S_OPT);
		chk(poll_byte, 8'h01);
		pulse_st(S_ERR);
		pulse_st(S_ST);
		chk(poll_byte, 8'h01);
		pulse_st(S_ERR);
		c.srq_mask = MASK_OVR;
		wr_cfg(c, 1'b0);
		rd_finish(1'b1, 1'b0);
		chk(poll_byte, 8'h0c);
		chk(srq_seen, 1'b0);
		pulse_st(S_REQ);
		chk(poll_byte, 8'h00);
		rd_finish(1'b0, 1'b1);
		chk(poll_byte, 8'h4a);
		chk(srq_seen, 1'b1);
	endtask : t_status

	task automatic t_poll();
		u_gbcs_ctrl_model.send(M_UNT);
		u_gbcs_ctrl_model.send(M_SPE);
		chk(poll_byte_valid, 1'b0);
		u_gbcs_ctrl_model.send(M_SPD);
		chk(poll_byte, 8'h0a);
		chk(srq_seen, 1'b0);
		rd_finish(1'b0, 1'b1);
		u_gbcs_ctrl_model.send(M_MTA);
		u_gbcs_ctrl_model.send(M_SPE);
		chk(poll_byte_valid, 1'b1);
		chk(poll_byte, 8'h4a);
		idle(1);
		chk(poll_byte[6], 1'b0);
		u_gbcs_ctrl_model.send(M_SPD);
		chk(poll_byte_valid, 1'b0);
	endtask : t_poll

	initial begin
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		chk(poll_byte, 8'h00);
		t_remote();
		t_lockout();
		t_ifc();
		t_clear();
		t_trigger();
		t_status();
		t_poll();
		complete_run();
	end
endmodule : gbcs_bus_cmd_tb_top
